// >>> bench/scag_gate_tb.sv
// self-checking bench of the security code access gate
`timescale 1ns/1ps
module scag_gate_tb;
	localparam logic [23:0] CODE = 24'hA55A3C; // arbitrary reference code
	localparam int LO [4] = '{0, 100, 200, 0};
	localparam int HI [4] = '{8, 130, 260, 260};
	typedef struct packed {
		logic       rs;
		logic [7:0] c;
		logic [7:0] a;
		logic [7:0] d;
		logic [4:0] nb;
		logic [1:0] k;
		logic [2:0] ec;
		logic       ae;
	} scag_row_t;

	logic       ref_clk;
	logic       reset;
	logic       card_clk;
	logic       card_rst;
	logic       io_drv;
	logic       io_out;
	logic       io_oe_n;
	logic       access_enabled;
	logic [2:0] error_count;
	logic       io_line;
	logic       inr;
	int         n_mismatch = 0;
	int         n_checks = 0;

	// k: 0 early release, 1 single cell op, 2 erase and write, 3 any
	scag_row_t rows [24] = '{
		'{1'b1, 8'h3F, 8'h00, 8'h00, 5'h18, 2'h0, 3'h7, 1'b0},
		'{1'b0, 8'h38, 8'h05, 8'h00, 5'h18, 2'h0, 3'h7, 1'b0},
		'{1'b0, 8'h39, 8'h00, 8'h06, 5'h17, 2'h0, 3'h7, 1'b0},
		'{1'b0, 8'h39, 8'h00, 8'h06, 5'h18, 2'h1, 3'h6, 1'b0},
		'{1'b0, 8'h33, 8'h01, 8'h00, 5'h18, 2'h0, 3'h6, 1'b0},
		'{1'b0, 8'h39, 8'h00, 8'h07, 5'h18, 2'h0, 3'h6, 1'b0},
		'{1'b0, 8'h39, 8'h00, 8'h04, 5'h18, 2'h1, 3'h4, 1'b0},
		'{1'b0, 8'h33, 8'h02, 8'h5A, 5'h18, 2'h0, 3'h4, 1'b0},
		'{1'b0, 8'h39, 8'h00, 8'h00, 5'h18, 2'h1, 3'h0, 1'b0},
		'{1'b0, 8'h33, 8'h01, 8'h00, 5'h18, 2'h0, 3'h0, 1'b0},
		'{1'b0, 8'h39, 8'h00, 8'h00, 5'h18, 2'h0, 3'h0, 1'b0},
		'{1'b0, 8'h33, 8'h01, 8'h3C, 5'h18, 2'h3, 3'h0, 1'b0},
		'{1'b0, 8'h33, 8'h02, 8'h5A, 5'h18, 2'h3, 3'h0, 1'b0},
		'{1'b0, 8'h33, 8'h03, 8'hA5, 5'h18, 2'h3, 3'h0, 1'b0},
		'{1'b1, 8'h39, 8'h00, 8'h03, 5'h18, 2'h1, 3'h3, 1'b0},
		'{1'b0, 8'h33, 8'h01, 8'h3C, 5'h18, 2'h3, 3'h3, 1'b0},
		'{1'b0, 8'h33, 8'h02, 8'h5A, 5'h18, 2'h3, 3'h3, 1'b0},
		'{1'b0, 8'h33, 8'h03, 8'hA5, 5'h18, 2'h3, 3'h3, 1'b1},
		'{1'b0, 8'h39, 8'h00, 8'hFF, 5'h18, 2'h1, 3'h7, 1'b1},
		'{1'b0, 8'h38, 8'h05, 8'h00, 5'h18, 2'h1, 3'h7, 1'b1},
		'{1'b0, 8'h3C, 8'h05, 8'h00, 5'h18, 2'h3, 3'h7, 1'b1},
		'{1'b0, 8'h38, 8'h05, 8'hFF, 5'h18, 2'h0, 3'h7, 1'b1},
		'{1'b0, 8'h3C, 8'h05, 8'h00, 5'h18, 2'h0, 3'h7, 1'b1},
		'{1'b0, 8'h39, 8'h01, 8'h77, 5'h18, 2'h2, 3'h7, 1'b1}
	};

	// open-drain wire with pull-up: low if either party pulls it
	assign io_line = io_drv & (io_oe_n | io_out);

	scag_gate #(
		.REF_CODE(CODE)
	) dut (
		.ref_clk        (ref_clk),
		.reset          (reset),
		.card_clk       (card_clk),
		.card_rst       (card_rst),
		.io_in          (io_line),
		.io_out         (io_out),
		.io_oe_n        (io_oe_n),
		.access_enabled (access_enabled),
		.error_count    (error_count)
	);

	scag_reader rdr (
		.ref_clk  (ref_clk),
		.io_line  (io_line),
		.card_clk (card_clk),
		.card_rst (card_rst),
		.io_drv   (io_drv)
	);

	// 20 MHz system clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] rxw();
		logic [31:0] v;
		for (int i = 0; i < 32; i++)
			v[i] = rdr.rx[i];
		return v;
	endfunction

	task automatic rd(input logic [7:0] c, input logic [31:0] e, input string nm);
		rdr.cmd(c, 8'h00, 8'h00, 24);
		rdr.run(33, 1'b0);
		chk(nm, e, rxw());
	endtask

	// power-on: memories reload, so only the power cycle clears unlock
	task automatic pwr_on(input bit with_atr);
		reset = 1'b1;
		repeat (16) @(negedge ref_clk);
		reset = 1'b0;
		repeat (5) @(negedge ref_clk);
		chk("line after power", 32'h1, 32'(io_oe_n));
		chk("open drain value", 32'h0, 32'(io_out));
		chk("unlock after power", 32'h0, 32'(access_enabled));
		chk("counter after power", 32'h7, 32'(error_count));
		if (with_atr) begin
			rdr.atr();
			chk("atr bits", 32'hFFFFFFFF, rxw());
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// rows, then protection and security reads, break, power cycle
	initial begin
		reset = 1'b1;
		foreach (rows[i]) begin
			if (rows[i].rs) pwr_on(1'b1);
			rdr.cmd(rows[i].c, rows[i].a, rows[i].d, int'(rows[i].nb));
			rdr.run(300, 1'b1);
			inr = rdr.lows >= LO[rows[i].k] && rdr.lows <= HI[rows[i].k];
			chk("pulses low", 32'h1, 32'(inr));
			chk("error count", 32'(rows[i].ec), 32'(error_count));
			chk("unlock", 32'(rows[i].ae), 32'(access_enabled));
			chk("line free", 32'h1, 32'(io_oe_n));
			$display("row %0d done", i);
		end
		rd(8'h34, 32'h00000020, "protection bits");
		rd(8'h31, {8'hA5, 8'h5A, 8'h77, 8'h07}, "open security");
		$display("reads done");
		rdr.cmd(8'h38, 8'h06, 8'h00, 24);
		rdr.run(5, 1'b0);
		rdr.brk();
		repeat (10) @(negedge ref_clk);
		chk("line after break", 32'h1, 32'(io_oe_n));
		chk("unlock after break", 32'h1, 32'(access_enabled));
		rd(8'h31, {8'hA5, 8'h5A, 8'h77, 8'h07}, "read after break");
		$display("break done");
		rdr.cmd(8'h30, 8'h04, 8'h00, 24);
		rdr.run(32, 1'b0);
		chk("main read", 32'hFF0000FF, rxw());
		rdr.brk();
		repeat (10) @(negedge ref_clk);
		chk("line after read break", 32'h1, 32'(io_oe_n));
		$display("main read done");
		pwr_on(1'b0);
		rdr.cmd(8'h39, 8'h00, 8'h06, 24);
		rdr.run(300, 1'b1);
		chk("counter before read", 32'h7, 32'(error_count));
		rd(8'h31, 32'h00000007, "locked security");
		rdr.cmd(8'h39, 8'h00, 8'h06, 24);
		rdr.run(300, 1'b1);
		chk("counter after read", 32'h6, 32'(error_count));
		$display("power cycle done");
		results();
	end

	// run needs about 22000 cycles; this limit leaves a wide margin
	initial begin
		repeat (90000) @(posedge ref_clk);
		n_mismatch++;
		results();
	end
endmodule

// >>> bench/scag_reader.sv
// card reader model: drives card clock, reset and the open-drain data line
`timescale 1ns/1ps
module scag_reader (
	input  wire logic ref_clk,
	input  wire logic io_line,
	output logic      card_clk,
	output logic      card_rst,
	output logic      io_drv
);
	logic rx [300];
	int   lows;

	// idle levels match the pin filter reset state
	initial begin
		card_clk = 1'b0;
		card_rst = 1'b0;
		io_drv   = 1'b1;
	end

	// a quarter of the 400 ns card clock, stepped on ref_clk falls
	task automatic q();
		repeat (2) @(negedge ref_clk);
	endtask

	// sample late in each high phase so the filter latency has passed
	task automatic run(input int n, input bit till_hi);
		lows = 0;
		for (int i = 0; i < n; i++) begin
			q();
			q();
			card_clk = 1'b1;
			q();
			q();
			rx[i] = io_line;
			card_clk = 1'b0;
			if (io_line === 1'b0 && lows == i) lows++;
			if (till_hi && io_line === 1'b1) break;
		end
	endtask

	// start, nb bits lsb first, then the extra pulse carrying the stop
	task automatic cmd(input logic [7:0] c, a, d, input int nb);
		logic [23:0] w;
		w = {d, a, c};
		q(); // let a clock fall just made reach the pin before rising again
		card_clk = 1'b1;
		q();
		io_drv = 1'b0;
		q();
		card_clk = 1'b0;
		for (int i = 0; i < nb; i++) begin
			q();
			io_drv = w[i];
			q();
			card_clk = 1'b1;
			q();
			q();
			card_clk = 1'b0;
		end
		q();
		io_drv = 1'b0;
		q();
		card_clk = 1'b1;
		q();
		io_drv = 1'b1;
		q();
		card_clk = 1'b0;
	endtask

	// address reset with clock high, then 32 bits and the closing pulse
	task automatic atr();
		card_clk = 1'b1;
		q();
		card_rst = 1'b1;
		q();
		card_clk = 1'b0;
		q();
		card_rst = 1'b0;
		run(33, 1'b0);
	endtask

	// break: reset raised while clock is low, held the 5 us minimum
	task automatic brk();
		q(); // clock low settled before reset rises
		card_rst = 1'b1;
		repeat (100) @(negedge ref_clk);
		card_rst = 1'b0;
	endtask
endmodule

// >>> design/scag_gate.sv
// security code access gate: card command engine, memories and unlock logic
`timescale 1ns/1ps
`include "scag_map.svh"
module scag_gate #(
	parameter logic [23:0] REF_CODE = 24'h000000 // arbitrary shipped code
) (
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       card_clk,
	input  wire logic       card_rst,
	input  wire logic       io_in,
	output logic            io_out,
	output logic            io_oe_n,
	output logic            access_enabled,
	output logic [2:0]      error_count
);
	import scag_pkg::*;

	scag_pin_if pins ();

	scag_pin_sync #(.N(3)) u_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pin_in  ({io_in, card_rst, card_clk}),
		.sig     (pins)
	);

	logic [7:0]  main_mem [0:255];
	logic [7:0]  sec_mem  [0:3];
	logic [31:0] prot_r;
	scag_state_t state_r;
	logic [23:0] cmd_sr_r;
	logic [4:0]  cmd_cnt_r;
	logic [8:0]  proc_left_r;
	logic        fail_r;
	logic [11:0] out_idx_r;
	logic [11:0] out_len_r;
	logic        out_started_r;
	scag_src_t   out_src_r;
	logic [7:0]  out_base_r;
	logic        unlocked_r;
	logic        alter_ok_r;
	logic        atr_pend_r;
	logic [1:0]  vstep_r;
	logic        io_oe_n_r;

	// pin events
	wire clk_hi    = pins.lvl[`SCAG_PIN_CLK];
	wire clk_fall  = pins.fall[`SCAG_PIN_CLK];
	wire clk_rise  = pins.rise[`SCAG_PIN_CLK];
	wire rst_rise  = pins.rise[`SCAG_PIN_RST];
	wire rst_fall  = pins.fall[`SCAG_PIN_RST];
	wire break_evt = rst_rise && !clk_hi;
	// our own drive also shows on the line, so only watch it while released
	wire start_evt = pins.fall[`SCAG_PIN_IO] && clk_hi && io_oe_n_r
		&& (state_r == SCAG_IDLE || state_r == SCAG_CMD);
	wire stop_evt  = pins.rise[`SCAG_PIN_IO] && clk_hi && state_r == SCAG_CMD;
	wire commit    = stop_evt && !rst_rise && !rst_fall;

	// command fields, first bit received lands in bit 0
	wire [7:0] ctl = cmd_sr_r[7:0];
	wire [7:0] adr = cmd_sr_r[15:8];
	wire [7:0] dat = cmd_sr_r[23:16];
	wire [7:0] old_main  = main_mem[adr];
	wire [7:0] old_sec   = sec_mem[adr[1:0]];
	wire [2:0] ec        = sec_mem[0][2:0];
	wire       low_area  = adr < `SCAG_PROT_BYTES;
	wire       prot_hit  = low_area && prot_r[adr[4:0]];
	wire       can_alter = unlocked_r && alter_ok_r;
	wire [7:0] sec_wval  = (adr == `SCAG_ADDR_EC) ? {5'h00, dat[2:0]} : dat;

	function automatic logic [8:0] pulses(input logic [7:0] o, input logic [7:0] n);
		logic er;
		logic wr;
		er = |(~o & n);
		wr = |(o & ~n);
		if (er && wr)
			pulses = `SCAG_PULSES_BOTH;
		else if (er || wr)
			pulses = `SCAG_PULSES_ONE;
		else
			pulses = `SCAG_PULSES_NONE;
	endfunction

	// exactly one set counter bit cleared, upper bits zero
	wire ec_only_clears = (dat[2:0] & ~ec) == 3'h0;
	wire ec_clear_one   = dat[7:3] == 5'h00 && ec_only_clears
		&& $countones(ec & ~dat[2:0]) == 1;

	logic        dec_fail;
	logic        dec_out;
	logic        dec_rd;
	scag_src_t   dec_src;
	logic [7:0]  dec_base;
	logic [11:0] dec_len;
	logic [8:0]  dec_pul;
	logic        main_we;
	logic        prot_we;
	logic        sec_we;
	logic [1:0]  vstep_nxt;
	logic        unlock_set;

	// command decode at the stop condition
	always_comb begin
		dec_fail   = 1'b0;
		dec_out    = 1'b0;
		dec_rd     = 1'b0;
		dec_src    = SCAG_SRC_MAIN;
		dec_base   = 8'h00;
		dec_len    = `SCAG_FIXED_BITS;
		dec_pul    = `SCAG_PULSES_NONE;
		main_we    = 1'b0;
		prot_we    = 1'b0;
		sec_we     = 1'b0;
		vstep_nxt  = 2'h0;
		unlock_set = 1'b0;
		if (cmd_cnt_r != `SCAG_CMD_PULSES) begin
			dec_fail = 1'b1;
		end else begin
			case (ctl)
				`SCAG_CMD_RD_MAIN: begin
					dec_out  = 1'b1;
					dec_rd   = 1'b1;
					dec_base = adr;
					dec_len  = {9'h100 - {1'b0, adr}, 3'h0};
				end
				`SCAG_CMD_RD_PROT: begin
					dec_out = 1'b1;
					dec_rd  = 1'b1;
					dec_src = SCAG_SRC_PROT;
				end
				`SCAG_CMD_RD_SEC: begin
					dec_out   = 1'b1;
					dec_rd    = 1'b1;
					dec_src   = SCAG_SRC_SEC;
					vstep_nxt = vstep_r;
				end
				`SCAG_CMD_UPD_MAIN: begin
					dec_fail = !can_alter || prot_hit;
					main_we  = 1'b1;
					dec_pul  = pulses(old_main, dat);
				end
				`SCAG_CMD_WR_PROT: begin
					dec_fail = !can_alter || !low_area || prot_hit;
					prot_we  = dat == old_main; // mismatch just suppresses
					dec_pul  = `SCAG_PULSES_ONE;
				end
				`SCAG_CMD_UPD_SEC: begin
					sec_we  = 1'b1;
					dec_pul = pulses(old_sec, sec_wval);
					if (adr > `SCAG_ADDR_SEC_TOP || !alter_ok_r)
						dec_fail = 1'b1;
					else if (!unlocked_r) begin
						// locked: counter only, bits one to zero
						dec_fail  = adr != `SCAG_ADDR_EC || !ec_only_clears;
						vstep_nxt = {1'b0, ec_clear_one && ec != 3'h0};
					end
				end
				`SCAG_CMD_COMPARE: begin
					dec_pul = `SCAG_PULSES_ONE;
					if (!unlocked_r) begin
						dec_fail   = vstep_r == 2'h0 || adr != {6'h00, vstep_r}
							|| dat != sec_mem[vstep_r];
						vstep_nxt  = vstep_r + 2'h1;
						unlock_set = vstep_r == 2'h3;
					end
				end
				default: dec_fail = 1'b1;
			endcase
		end
		if (dec_fail) begin
			dec_out    = 1'b0;
			dec_pul    = `SCAG_PULSES_FAIL;
			main_we    = 1'b0;
			prot_we    = 1'b0;
			sec_we     = 1'b0;
			vstep_nxt  = 2'h0;
			unlock_set = 1'b0;
		end
	end

	// outgoing bit selection
	wire [11:0] bit_idx  = out_started_r ? out_idx_r + 12'h001 : out_idx_r;
	wire [7:0]  rd_addr  = out_base_r + bit_idx[10:3];
	wire [7:0]  sec_byte = sec_mem[bit_idx[4:3]];
	wire        sec_bit  = (bit_idx[4:3] != 2'h0 && !unlocked_r) ? 1'b0
		: sec_byte[bit_idx[2:0]];
	wire        out_bit  = (out_src_r == SCAG_SRC_PROT) ? prot_r[bit_idx[4:0]]
		: (out_src_r == SCAG_SRC_SEC) ? sec_bit : main_mem[rd_addr][bit_idx[2:0]];

	// protocol sequencer and data line
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r       <= SCAG_IDLE;
			io_oe_n_r     <= 1'b1;
			cmd_sr_r      <= 24'h000000;
			cmd_cnt_r     <= 5'h00;
			proc_left_r   <= 9'h000;
			fail_r        <= 1'b0;
			out_idx_r     <= 12'h000;
			out_len_r     <= 12'h000;
			out_started_r <= 1'b0;
			out_src_r     <= SCAG_SRC_MAIN;
			out_base_r    <= 8'h00;
			atr_pend_r    <= 1'b0;
		end else if (break_evt) begin
			state_r    <= SCAG_IDLE;
			io_oe_n_r  <= 1'b1;
			atr_pend_r <= 1'b0;
		end else if (rst_rise) begin
			state_r    <= SCAG_IDLE; // address reset, answer follows on release
			io_oe_n_r  <= 1'b1;
			atr_pend_r <= 1'b1;
		end else if (rst_fall && atr_pend_r) begin
			state_r       <= SCAG_OUT;
			out_src_r     <= SCAG_SRC_MAIN;
			out_base_r    <= 8'h00;
			out_idx_r     <= 12'h000;
			out_len_r     <= `SCAG_FIXED_BITS;
			out_started_r <= 1'b1;
			io_oe_n_r     <= main_mem[0][0];
			atr_pend_r    <= 1'b0;
		end else begin
			unique case (state_r)
				SCAG_IDLE: begin
					if (start_evt) begin
						state_r   <= SCAG_CMD;
						cmd_cnt_r <= 5'h00;
					end
				end
				SCAG_CMD: begin
					if (start_evt)
						cmd_cnt_r <= 5'h00;
					else if (commit) begin
						state_r       <= dec_out ? SCAG_OUT : SCAG_PROC;
						proc_left_r   <= dec_pul;
						fail_r        <= dec_fail;
						out_src_r     <= dec_src;
						out_base_r    <= dec_base;
						out_len_r     <= dec_len;
						out_idx_r     <= 12'h000;
						out_started_r <= 1'b0;
					end else if (clk_rise && cmd_cnt_r != 5'h1F) begin
						cmd_cnt_r <= cmd_cnt_r + 5'h01;
						if (cmd_cnt_r < `SCAG_CMD_BITS)
							cmd_sr_r <= {pins.lvl[`SCAG_PIN_IO], cmd_sr_r[23:1]};
					end
				end
				SCAG_OUT: begin
					if (clk_fall) begin
						if (bit_idx >= out_len_r) begin
							state_r   <= SCAG_IDLE; // extra pulse releases
							io_oe_n_r <= 1'b1;
						end else begin
							io_oe_n_r     <= out_bit; // a one is a released line
							out_idx_r     <= bit_idx;
							out_started_r <= 1'b1;
						end
					end
				end
				SCAG_PROC: begin
					if (clk_fall) begin
						if (proc_left_r == 9'h000) begin
							state_r   <= SCAG_IDLE;
							io_oe_n_r <= 1'b1;
						end else begin
							io_oe_n_r   <= 1'b0;
							proc_left_r <= proc_left_r - 9'h001;
						end
					end
				end
			endcase
		end
	end

	// nonvolatile arrays; reset stands for the shipped contents
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < 256; i++)
				main_mem[i] <= `SCAG_MAIN_RESET;
			prot_r     <= 32'h00000000;
			sec_mem[0] <= `SCAG_EC_RESET;
			sec_mem[1] <= REF_CODE[7:0];
			sec_mem[2] <= REF_CODE[15:8];
			sec_mem[3] <= REF_CODE[23:16];
		end else if (commit) begin
			if (main_we)
				main_mem[adr] <= dat;
			if (prot_we)
				prot_r[adr[4:0]] <= 1'b1;
			if (sec_we)
				sec_mem[adr[1:0]] <= sec_wval;
		end
	end

	// access flags; break and answer-to-reset leave the unlock alone
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			unlocked_r <= 1'b0;
			alter_ok_r <= 1'b0;
			vstep_r    <= 2'h0;
		end else begin
			if (commit) begin
				vstep_r    <= vstep_nxt;
				unlocked_r <= unlocked_r || unlock_set;
			end
			if ((commit && dec_rd) || (rst_fall && atr_pend_r && !break_evt))
				alter_ok_r <= 1'b1;
		end
	end

	assign io_out         = 1'b0; // open drain, only the enable moves
	assign io_oe_n        = io_oe_n_r;
	assign access_enabled = unlocked_r;
	assign error_count    = sec_mem[0][2:0];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_power_up_released:
		assert property ($fell(reset) |-> io_oe_n && !access_enabled)
		else $error("line driven after power-up");
	a_break_releases:
		assert property (break_evt |=> io_oe_n && state_r == SCAG_IDLE)
		else $error("break did not release line");
	a_ec_only_clears:
		assert property (!unlocked_r |=> (error_count & ~$past(error_count)) == 3'h0)
		else $error("locked counter bit went to one");
	a_unlock_after_third:
		assert property ($rose(unlocked_r) |-> $past(vstep_r) == 2'h3 && $past(commit))
		else $error("unlock without three compares");
	a_unlock_sticky:
		assert property (unlocked_r |=> unlocked_r) else $error("unlock flag dropped");
	a_main_write_gate:
		assert property (commit && main_we |-> unlocked_r && alter_ok_r && !prot_hit)
		else $error("main write while locked or protected");
	a_attempt_needs_ec:
		assert property (commit && vstep_nxt == 2'h1 && !unlocked_r |-> ec != 3'h0)
		else $error("attempt began with empty counter");
	a_fail_release:
		assert property (commit && dec_fail |=> state_r == SCAG_PROC
			&& proc_left_r <= 9'h008) else $error("failure release too slow");
	a_sec_masked:
		assert property (state_r == SCAG_OUT && out_src_r == SCAG_SRC_SEC && !unlocked_r
			&& clk_fall && !rst_rise && bit_idx[4:3] != 2'h0 && bit_idx < out_len_r
			|=> !io_oe_n) else $error("reference bit shown locked");
	a_proc_drives_low:
		assert property (state_r == SCAG_PROC && clk_fall && !rst_rise
			&& proc_left_r != 9'h000 |=> !io_oe_n)
		else $error("processing did not pull line low");
endmodule

// >>> design/scag_map.svh
// constants of the security code access gate
//
// Contract
// - before unlock, error-counter bits may only go from one to zero.
// - compares present reference bytes one, two, three at 01h, 02h, 03h.
// - counter is never restored by itself; unlocked update with FFh erases it.
// - after unlock, write and erase allowed outside protected bytes until power loss.
// - a new attempt starts only while some counter bit is still one.
// - once unlocked, reference bytes are rewritable like ordinary data.
// - any deviation from the sequence fails and grants no access.
// - data line is released right after power-up.
// - no alteration after power-up until a read or answer-to-reset.
// - reset rising while clock low aborts, releases line, ready again.
// - failed compare, unknown command, bad pulse count release within 8 pulses.
// - writes to protected bytes or protection bits are failures too.
// - data bytes 0 to 31 lock through the protection bit of same index.
// - while locked, only the error counter is fully readable and writable; the code lets its bits only go from one to zero.
// - command starts on line fall and ends on line rise with clock high.
// - three bytes control, address, data, each sent least significant first.
// - locked security read shows reference bits low, counter truthfully.
// - processing drives line low after first clock fall until released.
`ifndef SCAG_MAP_SVH
`define SCAG_MAP_SVH

`define SCAG_PIN_CLK       0
`define SCAG_PIN_RST       1
`define SCAG_PIN_IO        2
`define SCAG_PIN_RST_LVL   3'h4

`define SCAG_CMD_RD_MAIN   8'h30
`define SCAG_CMD_UPD_MAIN  8'h38
`define SCAG_CMD_RD_PROT   8'h34
`define SCAG_CMD_WR_PROT   8'h3C
`define SCAG_CMD_RD_SEC    8'h31
`define SCAG_CMD_UPD_SEC   8'h39
`define SCAG_CMD_COMPARE   8'h33

`define SCAG_ADDR_EC       8'h00
`define SCAG_ADDR_SEC_TOP  8'h03
`define SCAG_PROT_BYTES    8'h20
`define SCAG_EC_RESET      8'h07
`define SCAG_MAIN_RESET    8'hFF

`define SCAG_CMD_BITS      5'h18
`define SCAG_CMD_PULSES    5'h19
`define SCAG_FIXED_BITS    12'h020
`define SCAG_PULSES_BOTH   9'h0FF
`define SCAG_PULSES_ONE    9'h07C
`define SCAG_PULSES_NONE   9'h002
`define SCAG_PULSES_FAIL   9'h002

`endif

// >>> design/scag_pin_if.sv
// filtered card pin levels and edges between synchroniser and gate
`timescale 1ns/1ps
interface scag_pin_if;
	logic [2:0] lvl;
	logic [2:0] rise;
	logic [2:0] fall;
	modport prod (output lvl, output rise, output fall);
	modport cons (input lvl, input rise, input fall);
endinterface

// >>> design/scag_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge detect
`timescale 1ns/1ps
`include "scag_map.svh"
module scag_pin_sync #(
	parameter int N = 3
) (
	input  wire logic         ref_clk,
	input  wire logic         reset,
	input  wire logic [N-1:0] pin_in,
	scag_pin_if.prod          sig
);
	import scag_pkg::*;

	// idle pin levels, so no false edge follows reset
	localparam logic [N-1:0] RST_LVL = N'(`SCAG_PIN_RST_LVL);

	logic [N-1:0] s1_r;
	logic [N-1:0] s2_r;
	logic [N-1:0] s3_r;
	logic [N-1:0] filt_r;
	logic [N-1:0] filt_d_r;

	// a level only counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pin
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					s1_r[g]     <= RST_LVL[g];
					s2_r[g]     <= RST_LVL[g];
					s3_r[g]     <= RST_LVL[g];
					filt_r[g]   <= RST_LVL[g];
					filt_d_r[g] <= RST_LVL[g];
				end else begin
					s1_r[g]     <= pin_in[g];
					s2_r[g]     <= s1_r[g];
					s3_r[g]     <= s2_r[g];
					filt_r[g]   <= (s2_r[g] == s3_r[g]) ? s3_r[g] : filt_r[g];
					filt_d_r[g] <= filt_r[g];
				end
			end
		end
	endgenerate

	// edges are single ref_clk pulses
	assign sig.lvl  = filt_r;
	assign sig.rise = filt_r & ~filt_d_r;
	assign sig.fall = ~filt_r & filt_d_r;
endmodule

// >>> design/scag_pkg.sv
// types of the security code access gate
package scag_pkg;
	typedef enum logic [1:0] {
		SCAG_IDLE = 2'h0,
		SCAG_CMD  = 2'h1,
		SCAG_PROC = 2'h3,
		SCAG_OUT  = 2'h2
	} scag_state_t;

	typedef enum logic [1:0] {
		SCAG_SRC_MAIN = 2'h0,
		SCAG_SRC_PROT = 2'h1,
		SCAG_SRC_SEC  = 2'h2
	} scag_src_t;
endpackage
